// >>> logic/igdes_defines.svh
// constants of the input gearbox deserializer
// assumes inclusion by bare name from the package and the design files
`ifndef IGDES_DEFINES_SVH
`define IGDES_DEFINES_SVH

// word lengths of the three modes
`define IGDES_LEN_VIDEO  4'h7
`define IGDES_LEN_EIGHT  4'h8
`define IGDES_LEN_FOUR   4'h4
// serial history kept by each lane, at least two words deep
`define IGDES_HIST_W     16
// reset values
`define IGDES_RST_WORD   8'h00
`define IGDES_RST_POS    3'h0
`define IGDES_RST_CNT    4'h0
// latency in ref_clk_in edges from a lane word toggle to the valid pulse
`define IGDES_XING_LAT   3

`endif

// >>> logic/igdes_pkg.sv
// types shared by the input gearbox deserializer files
// assumes igdes_defines.svh is on the include path
package igdes_pkg;
`include "igdes_defines.svh"

  // deserializer configuration
  typedef enum logic [1:0] {
    mode_video = 2'b00,
    mode_eight = 2'b01,
    mode_dual  = 2'b10
  } igdes_mode_type;

  // one lane's word as handed over to the system clock side
  typedef struct packed {
    logic       tgl;
    logic [2:0] pos;
    logic [7:0] data;
  } igdes_lane_type;

  // word length of a mode; the unused code behaves as eight bits
  function automatic logic [3:0] igdes_len_f(input igdes_mode_type m);
    case (m)
      mode_video: igdes_len_f = `IGDES_LEN_VIDEO;
      mode_dual:  igdes_len_f = `IGDES_LEN_FOUR;
      default:    igdes_len_f = `IGDES_LEN_EIGHT;
    endcase
  endfunction

endpackage

// >>> logic/igdes_lane.sv
// one deserializing lane: both-edge capture and word alignment
// assumes a free running fast edge clock and a reset synchronous to it
`timescale 1ns/100ps
`include "igdes_defines.svh"
module igdes_lane #(
  parameter int WORD_W = 8
) (
  input  wire logic             fast_edge_clock_in,
  input  wire logic             fast_rst_in,
  input  wire logic             ser_in,
  input  wire logic [3:0]       word_len_in,
  input  wire logic             align_select_zero_in,
  output igdes_pkg::igdes_lane_type lane_out
);
  import igdes_pkg::*;

  if (WORD_W != 8) begin : g_bad_width
    $error("igdes_lane supports an eight bit word only");
  end

  logic                      rise_q;
  logic                      fall_q;
  logic [`IGDES_HIST_W-1:0]  hist_q;
  logic [`IGDES_HIST_W-1:0]  hist_d;
  logic [3:0]                cnt_q;
  logic [3:0]                cnt_d;
  logic [4:0]                pend;
  logic [4:0]                pend_s;
  logic                      word_update;
  logic [2:0]                pos_q;
  logic [7:0]                word_q;
  logic                      tgl_q;

  // oldest len bits of the pending ones, oldest bit at the top
  function automatic logic [7:0] pick_f(input logic [`IGDES_HIST_W-1:0] h,
                                        input logic [4:0] p, input logic [3:0] len);
    logic [`IGDES_HIST_W-1:0] s;
    logic [7:0]               m;
    s = h >> (p - {1'h0, len});
    m = (8'h01 << len) - 8'h01;
    pick_f = s[7:0] & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // stage one: sample on both edges
  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst_in) rise_q <= 1'h0;
    else rise_q <= ser_in;
  end

  always_ff @(negedge fast_edge_clock_in) begin
    if (fast_rst_in) fall_q <= 1'h0;
    else fall_q <= ser_in;
  end

  ////////////////////////////////////////////////////////////////////////
  // stage two: two bits per cycle, a slip drops the oldest pending bit
  always_comb begin
    hist_d = {hist_q[`IGDES_HIST_W-3:0], rise_q, fall_q};
    pend   = {1'h0, cnt_q} + 5'h02;
    if (align_select_zero_in) pend_s = pend - 5'h01;
    else pend_s = pend;
    word_update = (pend_s >= {1'h0, word_len_in});
    if (word_update) cnt_d = 4'(pend_s - {1'h0, word_len_in});
    else cnt_d = pend_s[3:0];
  end

  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst_in) hist_q <= '0;
    else hist_q <= hist_d;
  end

  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst_in) cnt_q <= `IGDES_RST_CNT;
    else cnt_q <= cnt_d;
  end

  // word is held until the next one, long enough for the slow side to copy it
  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst_in) begin
      word_q <= `IGDES_RST_WORD;
      tgl_q  <= 1'h0;
    end else if (word_update) begin
      word_q <= pick_f(hist_d, pend_s, word_len_in);
      tgl_q  <= ~tgl_q;
    end
  end

  // boundary position, wraps at the word length
  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst_in) pos_q <= `IGDES_RST_POS;
    else if (align_select_zero_in) begin
      if ({1'h0, pos_q} + 4'h1 >= word_len_in) pos_q <= `IGDES_RST_POS;
      else pos_q <= pos_q + 3'h1;
    end
  end

  assign lane_out = '{tgl: tgl_q, pos: pos_q, data: word_q};

  ////////////////////////////////////////////////////////////////////////
  // checks on the fast side
  property p_stage_one;
    @(posedge fast_edge_clock_in) disable iff (fast_rst_in)
    !$past(fast_rst_in, 2) |-> hist_q[1] == $past(ser_in, 2);
  endproperty
  a_stage_one: assert property (p_stage_one)
    else $error("rising edge sample lost on its way into the history");

  property p_slip_wrap;
    @(posedge fast_edge_clock_in) disable iff (fast_rst_in)
    align_select_zero_in && ({1'h0, pos_q} + 4'h1 == word_len_in) |=> pos_q == 3'h0;
  endproperty
  a_slip_wrap: assert property (p_slip_wrap)
    else $error("alignment position did not wrap at the word length");

  property p_slip_step;
    @(posedge fast_edge_clock_in) disable iff (fast_rst_in)
    align_select_zero_in && ({1'h0, pos_q} + 4'h1 < word_len_in)
      |=> pos_q == $past(pos_q) + 3'h1;
  endproperty
  a_slip_step: assert property (p_slip_step)
    else $error("alignment position did not advance by one");

  property p_eight_period;
    @(posedge fast_edge_clock_in) disable iff (fast_rst_in)
    (word_update && word_len_in == `IGDES_LEN_EIGHT)
      ##1 (!align_select_zero_in && !word_update && word_len_in == `IGDES_LEN_EIGHT)[*3]
      ##1 (!align_select_zero_in && word_len_in == `IGDES_LEN_EIGHT)
      |-> word_update;
  endproperty
  a_eight_period: assert property (p_eight_period)
    else $error("eight bit word not produced every four fast cycles");

  c_slip: cover property (@(posedge fast_edge_clock_in) disable iff (fast_rst_in)
    align_select_zero_in ##1 word_update);

endmodule

// >>> logic/igdes_top.sv
// input gearbox deserializer: serial bits on a fast edge clock become
// parallel words on the system clock, with word boundary alignment
// assumes fast_edge_clock_in runs freely and rst_in is held for four of its periods
//
// Notes on behaviour
// - each io_cell_group has one gearbox, natively one serial bit to eight
// - modes: one-to-seven, one single one-to-eight, or two separate one-to-four
// - seven bit words sit in q bits 6:0; eight bit words fill 7:0
// - dual mode: first cell lane drives bits 7:4, third cell lane 3:0
// - three register stages between the serial input and the parallel output
// - stage one samples serial data on both fast clock edges
// - stage two aligns words under update and select-zero controls
// - stage three hands the word to core registered on the system clock
// - serial data is taken after the first cell's input delay element
`timescale 1ns/100ps
`include "igdes_defines.svh"
module igdes_top #(
  parameter int WORD_W = 8
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     fast_edge_clock_in,
  input  wire logic                     ser_first_io_logic_cell_in,
  input  wire logic                     ser_third_io_logic_cell_in,
  input  igdes_pkg::igdes_mode_type     mode_in,
  input  wire logic                     word_align_request_in,
  output logic [7:0]                    q_out,
  output logic                          word_valid_out,
  output logic [2:0]                    align_pos_out
);
  import igdes_pkg::*;

  if (WORD_W != 8) begin : g_bad_width
    $error("igdes_top supports an eight bit word only");
  end

  // system clock side
  logic            req_q;
  logic            req_tgl_q;
  logic            a_s1_q;
  logic            a_s2_q;
  logic            a_s3_q;
  logic            c_s1_q;
  logic            c_s2_q;
  logic            c_s3_q;
  logic            a_new;
  logic            c_new;
  logic [7:0]      q_q;
  logic            valid_q;
  logic [2:0]      pos_q;

  // fast clock side
  logic            frst_s1_q;
  logic            frst_s2_q;
  logic            frst_s3_q;
  logic            fast_rst;
  igdes_mode_type  fmode_s1_q;
  igdes_mode_type  fmode_s2_q;
  igdes_mode_type  fmode_s3_q;
  igdes_mode_type  fmode_q;
  logic            freq_s1_q;
  logic            freq_s2_q;
  logic            freq_s3_q;
  logic            align_select_zero;
  logic [3:0]      lane_a_len;
  igdes_lane_type  lane_a_w;
  igdes_lane_type  lane_c_w;

  ////////////////////////////////////////////////////////////////////////
  // align request: each rising edge is one request, sent as a toggle
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) req_q <= 1'h0;
    else req_q <= word_align_request_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) req_tgl_q <= 1'h0;
    else if (word_align_request_in && !req_q) req_tgl_q <= ~req_tgl_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // reset into the fast domain; held while either late stage still sees it
  always_ff @(posedge fast_edge_clock_in) begin
    frst_s1_q <= rst_in;
    frst_s2_q <= frst_s1_q;
    frst_s3_q <= frst_s2_q;
  end

  assign fast_rst = frst_s2_q | frst_s3_q;

  // mode into the fast domain, taken once two stages agree
  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst) begin
      fmode_s1_q <= mode_eight;
      fmode_s2_q <= mode_eight;
      fmode_s3_q <= mode_eight;
    end else begin
      fmode_s1_q <= mode_in;
      fmode_s2_q <= fmode_s1_q;
      fmode_s3_q <= fmode_s2_q;
    end
  end

  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst) fmode_q <= mode_eight;
    else if (fmode_s2_q == fmode_s3_q) fmode_q <= fmode_s3_q;
  end

  // request toggle into the fast domain
  always_ff @(posedge fast_edge_clock_in) begin
    if (fast_rst) begin
      freq_s1_q <= 1'h0;
      freq_s2_q <= 1'h0;
      freq_s3_q <= 1'h0;
    end else begin
      freq_s1_q <= req_tgl_q;
      freq_s2_q <= freq_s1_q;
      freq_s3_q <= freq_s2_q;
    end
  end

  // a slip costs one bit of the stream; both lanes slip together in dual mode
  assign align_select_zero = freq_s2_q ^ freq_s3_q;
  assign lane_a_len        = igdes_len_f(fmode_q);

  ////////////////////////////////////////////////////////////////////////
  // lanes: first cell carries the single word, third cell the low nibble
  igdes_lane #(
    .WORD_W               (WORD_W)
  ) u_lane_first (
    .fast_edge_clock_in   (fast_edge_clock_in),
    .fast_rst_in          (fast_rst),
    .ser_in               (ser_first_io_logic_cell_in),
    .word_len_in          (lane_a_len),
    .align_select_zero_in (align_select_zero),
    .lane_out             (lane_a_w)
  );

  igdes_lane #(
    .WORD_W               (WORD_W)
  ) u_lane_third (
    .fast_edge_clock_in   (fast_edge_clock_in),
    .fast_rst_in          (fast_rst),
    .ser_in               (ser_third_io_logic_cell_in),
    .word_len_in          (`IGDES_LEN_FOUR),
    .align_select_zero_in (align_select_zero),
    .lane_out             (lane_c_w)
  );

  ////////////////////////////////////////////////////////////////////////
  // word toggles into the system domain; data is already stable by then
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      a_s1_q <= 1'h0;
      a_s2_q <= 1'h0;
      a_s3_q <= 1'h0;
      c_s1_q <= 1'h0;
      c_s2_q <= 1'h0;
      c_s3_q <= 1'h0;
    end else begin
      a_s1_q <= lane_a_w.tgl;
      a_s2_q <= a_s1_q;
      a_s3_q <= a_s2_q;
      c_s1_q <= lane_c_w.tgl;
      c_s2_q <= c_s1_q;
      c_s3_q <= c_s2_q;
    end
  end

  assign a_new = a_s2_q ^ a_s3_q;
  assign c_new = c_s2_q ^ c_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // mode_in is read unsynchronised here, so it may change only under reset
  // stage three: parallel word registered on the system clock
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) q_q <= `IGDES_RST_WORD;
    else begin
      case (mode_in)
        mode_dual: begin
          if (a_new) q_q[7:4] <= lane_a_w.data[3:0];
          if (c_new) q_q[3:0] <= lane_c_w.data[3:0];
        end
        mode_video: begin
          if (a_new) q_q <= {1'h0, lane_a_w.data[6:0]};
        end
        default: begin
          if (a_new) q_q <= lane_a_w.data;
        end
      endcase
    end
  end

  // valid pulses with each new word; dual mode pulses for either nibble
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) valid_q <= 1'h0;
    else if (mode_in == mode_dual) valid_q <= a_new | c_new;
    else valid_q <= a_new;
  end

  // position travels with the word so the multi-bit copy is stable
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) pos_q <= `IGDES_RST_POS;
    else if (a_new) pos_q <= lane_a_w.pos;
  end

  assign q_out          = q_q;
  assign word_valid_out = valid_q;
  assign align_pos_out  = pos_q;

  ////////////////////////////////////////////////////////////////////////
  // checks on the system side
  property p_rst_clear;
    @(posedge ref_clk_in)
    rst_in |=> q_out == 8'h00 && !word_valid_out && align_pos_out == 3'h0;
  endproperty
  a_rst_clear: assert property (p_rst_clear)
    else $error("reset did not clear the outputs");

  property p_hold;
    @(posedge ref_clk_in) disable iff (rst_in)
    !word_valid_out && !$past(rst_in) |-> $stable(q_out);
  endproperty
  a_hold: assert property (p_hold)
    else $error("parallel word changed without a valid pulse");

  property p_single_pulse;
    @(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && mode_in != mode_dual |=> !word_valid_out;
  endproperty
  a_single_pulse: assert property (p_single_pulse)
    else $error("valid pulse longer than one cycle");

  property p_video_top;
    @(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && mode_in == mode_video && $past(mode_in) == mode_video
      |-> q_out[7] == 1'h0;
  endproperty
  a_video_top: assert property (p_video_top)
    else $error("seven bit word leaked into bit seven");

  property p_eight_data;
    @(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && mode_in == mode_eight && $past(mode_in) == mode_eight
      |-> q_out == $past(lane_a_w.data);
  endproperty
  a_eight_data: assert property (p_eight_data)
    else $error("eight bit word differs from the lane word");

  property p_dual_hi;
    @(posedge ref_clk_in) disable iff (rst_in)
    a_new && mode_in == mode_dual |=> q_out[7:4] == $past(lane_a_w.data[3:0]);
  endproperty
  a_dual_hi: assert property (p_dual_hi)
    else $error("first cell nibble not on bits seven to four");

  property p_dual_lo;
    @(posedge ref_clk_in) disable iff (rst_in)
    c_new && mode_in == mode_dual |=> q_out[3:0] == $past(lane_c_w.data[3:0]);
  endproperty
  a_dual_lo: assert property (p_dual_lo)
    else $error("third cell nibble not on bits three to zero");

  property p_pipeline;
    @(posedge ref_clk_in) disable iff (rst_in)
    ($changed(lane_a_w.tgl) && mode_in != mode_dual) ##1 (!rst_in)[*2] |=> word_valid_out;
  endproperty
  a_pipeline: assert property (p_pipeline)
    else $error("word did not reach the core three edges after the toggle");

  // request decoding: only a rising level counts, a held level must not act again
  property p_req_edge;
    @(posedge ref_clk_in) disable iff (rst_in)
    word_align_request_in && !req_q |=> req_tgl_q != $past(req_tgl_q);
  endproperty
  a_req_edge: assert property (p_req_edge)
    else $error("align request edge not passed on");

  property p_req_quiet;
    @(posedge ref_clk_in) disable iff (rst_in)
    !(word_align_request_in && !req_q) |=> $stable(req_tgl_q);
  endproperty
  a_req_quiet: assert property (p_req_quiet)
    else $error("align request acted without a rising edge");

  // the toggle crossing must give exactly one slip cycle per request
  property p_slip_pulse;
    @(posedge fast_edge_clock_in) disable iff (fast_rst)
    align_select_zero |=> !align_select_zero;
  endproperty
  a_slip_pulse: assert property (p_slip_pulse)
    else $error("one align request slipped the boundary twice");

  c_video: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && mode_in == mode_video);
  c_eight: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && mode_in == mode_eight);
  c_dual: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && mode_in == mode_dual && a_new);
  c_align: cover property (@(posedge ref_clk_in) disable iff (rst_in)
    word_valid_out && align_pos_out != 3'h0);

endmodule

// >>> sim/igdes_ser_src.sv
// serial source model for both lanes of the input gearbox deserializer
// assumes a free running fast edge clock; patterns change only during reset
`timescale 1ns/100ps
module igdes_ser_src (
  input  wire logic       fast_edge_clock_in,
  input  wire logic [7:0] pat_a_in,
  input  wire logic [3:0] pat_c_in,
  input  wire logic [3:0] len_a_in,
  output logic            ser_a_out,
  output logic            ser_c_out
);
  int idx_a = 0;
  int idx_c = 0;

  //////////////////////////////////////////////////////////////////////////////
  // a new bit every half period, moved a quarter period after each edge
  // so both capturing edges see a settled level, msb of the pattern first
  initial begin
    ser_a_out = 1'b0;
    ser_c_out = 1'b0;
  end
  always @(fast_edge_clock_in) begin
    #31.25;
    if (idx_a >= int'(len_a_in)) begin
      idx_a = 0;
    end
    if (idx_c >= 4) begin
      idx_c = 0;
    end
    ser_a_out = pat_a_in[int'(len_a_in) - 1 - idx_a];
    ser_c_out = pat_c_in[3 - idx_c];
    idx_a = idx_a + 1;
    idx_c = idx_c + 1;
  end
endmodule

// >>> sim/input_gearbox_deserializer_bench.sv
// self-checking bench of the input gearbox deserializer, one task a mode
// assumes igdes_pkg compiled first and the serial source model beside it
`timescale 1ns/100ps
module input_gearbox_deserializer_bench;
  import igdes_pkg::*;
  logic           ref_clk_in = 1'b0;
  logic           rst_in     = 1'b1;
  logic           fast_clk   = 1'b0;
  logic           ser_a;
  logic           ser_c;
  logic           align_req  = 1'b0;
  igdes_mode_type mode       = mode_eight;
  logic [7:0]     q;
  logic           valid;
  logic [2:0]     pos;
  logic [7:0]     pat_a      = 8'hca;
  logic [3:0]     pat_c      = 4'he;
  logic [3:0]     len_a      = 4'h8;
  int             err_total  = 0;
  int             compares   = 0;

  //////////////////////////////////////////////////////////////////////////////
  // clocks; fast edges offset so they never meet a system clock edge
  always #2 ref_clk_in = ~ref_clk_in;
  initial begin
    #1.3;
    forever #62.5 fast_clk = ~fast_clk;
  end

  igdes_top uut (
    .ref_clk_in                 (ref_clk_in),
    .rst_in                     (rst_in),
    .fast_edge_clock_in         (fast_clk),
    .ser_first_io_logic_cell_in (ser_a),
    .ser_third_io_logic_cell_in (ser_c),
    .mode_in                    (mode),
    .word_align_request_in      (align_req),
    .q_out                      (q),
    .word_valid_out             (valid),
    .align_pos_out              (pos)
  );

  igdes_ser_src src (
    .fast_edge_clock_in (fast_clk),
    .pat_a_in           (pat_a),
    .pat_c_in           (pat_c),
    .len_a_in           (len_a),
    .ser_a_out          (ser_a),
    .ser_c_out          (ser_c)
  );

  //////////////////////////////////////////////////////////////////////////////
  // reporting
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // waits n valid pulses, sampled at falling edges; gap is the idle count
  task automatic wait_words(input int n, output int gap);
    int c;
    gap = 0;
    for (int w = 0; w < n; w++) begin
      c = 0;
      @(negedge ref_clk_in);
      while (valid !== 1'b1) begin
        c++;
        if (c > 400) begin
          err_total++;
          $display("[ERR] word_valid_out expected 1 seen none");
          stop_test();
        end
        @(negedge ref_clk_in);
      end
      gap = c;
    end
  endtask

  // word that starts s bits into a repeating pattern, oldest bit at the msb
  function automatic logic [7:0] rot(input logic [7:0] p, input int len, input int s);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < len; i++) begin
      r[len - 1 - i] = p[len - 1 - ((i + s) % len)];
    end
    return r;
  endfunction

  function automatic logic [7:0] exp_q(input igdes_mode_type m, input int len,
                                       input int s, input int sc);
    logic [7:0] ra;
    logic [7:0] rc;
    ra = rot(pat_a, len, s);
    rc = rot({4'h0, pat_c}, 4, sc);
    if (m == mode_dual) begin
      return {ra[3:0], rc[3:0]};
    end
    return ra;
  endfunction

  // mid-run reset; outputs must read zero while it is held
  task automatic do_reset(input igdes_mode_type m);
    @(negedge ref_clk_in);
    rst_in = 1'b1;
    mode   = m;
    repeat (140) @(negedge ref_clk_in);
    check("q_out in reset", 8'h00, q);
    check("word_valid_out in reset", 8'h00, {7'h0, valid});
    check("align_pos_out in reset", 8'h00, {5'h0, pos});
    rst_in = 1'b0;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // one mode: find the free running boundary, then slip it len + 1 times
  // with the request held high for a whole word to prove level = one request
  task automatic run_mode(input igdes_mode_type m, input int len);
    int         g;
    int         s;
    int         sc;
    int         nw;
    s  = -1;
    sc = 0;
    nw = (m == mode_dual) ? 6 : 3;
    len_a = 4'(len);
    do_reset(m);
    wait_words(6, g);
    if (m == mode_eight) begin
      compares++;
      if (g < 123 || g > 125) begin
        err_total++;
        $display("[ERR] word gap expected 124 seen %0d", g);
      end
    end
    for (int a = 0; a < len; a++) begin
      for (int c = 0; c < ((m == mode_dual) ? 4 : 1); c++) begin
        if (exp_q(m, len, a, c) === q) begin
          s  = a;
          sc = c;
        end
      end
    end
    if (s < 0) begin
      check("q_out rotation", exp_q(m, len, 0, 0), q);
      s = 0;
    end
    check("align_pos_out before slips", 8'h00, {5'h0, pos});
    for (int k = 1; k <= len + 1; k++) begin
      align_req = 1'b1;
      wait_words(1, g);
      align_req = 1'b0;
      wait_words(nw, g);
      s  = (s + 1) % len;
      sc = (m == mode_dual) ? (sc + 1) % 4 : 0;
      check("q_out after slip", exp_q(m, len, s, sc), q);
      check("align_pos_out", 8'(k % len), {5'h0, pos});
    end
  endtask

  task automatic test_eight();
    pat_a = 8'hca;
    run_mode(mode_eight, 8);
  endtask

  task automatic test_video();
    pat_a = 8'h64;
    run_mode(mode_video, 7);
  endtask

  task automatic test_dual();
    pat_a = 8'h08;
    pat_c = 4'he;
    run_mode(mode_dual, 4);
  endtask

  task automatic test_spare_code();
    pat_a = 8'h3a;
    run_mode(igdes_mode_type'(2'b11), 8);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    test_eight();
    test_video();
    test_dual();
    test_spare_code();
    stop_test();
  end
endmodule
